// ==== logic/i2c_slave_defines.svh ====
// constants of the two-wire register access slave
// assumes a 100 MHz core clock; included by bare name
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH

`define SLAVE_ADDR_STRAP_LOW   7'h54
`define SLAVE_ADDR_STRAP_HIGH  7'h55
`define DIR_WRITE              1'h0
`define DIR_READ               1'h1
`define BITS_PER_BYTE          4'h8
`define BYTE_IDX_ADDR          2'h0
`define BYTE_IDX_POINTER       2'h1
`define BYTE_IDX_DATA          2'h2
`define WR_FIFO_DEPTH          16
`define CORE_CLK_PERIOD_NS     10
`define SDA_HOLD_MIN_NS        300
`define SDA_HOLD_CYCLES \
   ((`SDA_HOLD_MIN_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`endif

// ==== logic/i2c_slave_pkg.sv ====
// types shared by the register access slave, its port checks and its bench
// assumes nothing of its surroundings
`default_nettype none
package i2c_slave_pkg;

   typedef enum logic [4:0]
   {
      ST_IDLE   = 5'h01,
      ST_RX     = 5'h02,
      ST_RX_ACK = 5'h04,
      ST_TX     = 5'h08,
      ST_TX_ACK = 5'h10
   } slave_state_t;

   typedef struct packed
   {
      logic [7:0] reg_addr;
      logic [7:0] reg_data;
   } wr_cmd_t;

endpackage : i2c_slave_pkg
`default_nettype wire

// ==== logic/wr_cmd_fifo.sv ====
// synchronous fifo with a registered head word
// assumes DEPTH is a power of two; one clock for both sides
`timescale 1ns/100ps
`default_nettype none
module wr_cmd_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic             out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic             push;
   logic             pop;

   // the head register counts as one extra slot beyond DEPTH
   assign in_ready  = (count_reg != CW'(DEPTH));
   assign push      = in_valid & in_ready;
   assign pop       = (count_reg != '0) & (~out_valid_reg | out_ready);
   assign out_valid = out_valid_reg;
   assign out_data  = out_data_reg;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         if (push & ~pop)
         begin
            count_reg <= count_reg + CW'(1);
         end
         else if (pop & ~push)
         begin
            count_reg <= count_reg - CW'(1);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end
      else if (pop)
      begin
         out_valid_reg <= 1'b1;
         out_data_reg  <= mem[rd_ptr_reg];
      end
      else if (out_ready)
      begin
         out_valid_reg <= 1'b0;
      end
   end

endmodule : wr_cmd_fifo
`default_nettype wire

// ==== logic/i2c_register_access_slave.sv ====
// two-wire serial slave giving a bus master access to a register map
// assumes the register map sits on core_clk, takes writes from the
// queue below and answers rd_addr with rd_data within one scl high time
`timescale 1ns/100ps
`default_nettype none
`include "i2c_slave_defines.svh"

// What this block does
// [R1] sda is sampled at scl rising; master changes sda only while scl low
// [R2] sda toggling while scl high mid-transfer abandons and discards it
// [R3] sda falling with scl high is start; rising with scl high is stop
// [R4] bus counts as busy from start until stop, idle otherwise
// [R5] repeated start behaves as a first start: byte count and match restart
// [R6] bytes are eight bits, most significant bit first, both directions
// [R7] master clocks the acknowledge; the transmitter releases sda during it
// [R8] receiver pulls sda low on the ninth clock; addressed slave acks all but a data byte met by a full write queue
// [R9] first byte is seven-bit address plus direction, zero write, one read
// [R10] slave address is 54h with strap low and 55h with strap high
// [R11] write: byte after address is the pointer, next byte is the data
// [R12] written value takes effect at scl rise of the slave's final ack
// [R13] master reads by writing the pointer, then repeated start and read
// [R14] pointer advances by one after each data byte read or written
// [R15] master should auto-increment only across the pattern command block
// [R16] mismatched address gets no ack; slave ignores bus until next start
// [R17] read: slave drives register bits; master ack continues, nack ends
module i2c_register_access_slave
#(
   parameter int WR_DEPTH  = `WR_FIFO_DEPTH,
   parameter int HOLD_CYC  = `SDA_HOLD_CYCLES
)
(
   input  wire logic                     core_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     scl_i,
   input  wire logic                     sda_i,
   output logic                          sda_o,
   output logic                          sda_oe_n,
   input  wire logic                     addr_sel,
   output logic                          wr_valid,
   input  wire logic                     wr_ready,
   output i2c_slave_pkg::wr_cmd_t        wr_cmd,
   output logic                          [7:0] rd_addr,
   input  wire logic                     [7:0] rd_data,
   output logic                          bus_busy
);

   localparam int HW = $clog2(HOLD_CYC + 1);

   // pin synchronisers and edge history
   logic                        scl_meta_reg;
   logic                        scl_sync_reg;
   logic                        scl_prev_reg;
   logic                        sda_meta_reg;
   logic                        sda_sync_reg;
   logic                        sda_prev_reg;
   logic                        sel_meta_reg;
   logic                        sel_sync_reg;

   // protocol state
   i2c_slave_pkg::slave_state_t state_reg;
   logic [3:0]                  bit_cnt_reg;
   logic [1:0]                  byte_cnt_reg;
   logic [7:0]                  shift_reg;
   logic [7:0]                  pointer_reg;
   logic                        dir_reg;
   logic                        master_ack_reg;
   logic                        busy_reg;

   // sda output timing
   logic                        sda_oe_n_reg;
   logic [HW-1:0]               hold_cnt_reg;

   // decoded events
   logic                        scl_rise;
   logic                        scl_fall;
   logic                        start_det;
   logic                        stop_det;
   logic                        byte_in_done;
   logic                        accept_byte;
   logic                        commit_write;
   logic                        want_low;
   logic [6:0]                  own_addr;

   // queue between the serial side and the register map
   logic                        q_in_ready;
   i2c_slave_pkg::wr_cmd_t      q_in_data;

   function automatic logic [7:0] next_ptr(input logic [7:0] p);
      next_ptr = p + 8'h01;
   endfunction : next_ptr

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end
      else
      begin
         scl_meta_reg <= scl_i;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= sda_i;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
      end
   end

   // strap is re-sampled continuously; it should only move when idle
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         sel_meta_reg <= 1'b0;
         sel_sync_reg <= 1'b0;
      end
      else
      begin
         sel_meta_reg <= addr_sel;
         sel_sync_reg <= sel_meta_reg;
      end
   end

   assign own_addr = sel_sync_reg ? `SLAVE_ADDR_STRAP_HIGH
                                  : `SLAVE_ADDR_STRAP_LOW; // R10

   assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
   assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
   // both samples high so a start is never mistaken at an scl edge
   assign start_det = scl_sync_reg & scl_prev_reg
                      & sda_prev_reg & ~sda_sync_reg; // R3
   assign stop_det  = scl_sync_reg & scl_prev_reg
                      & ~sda_prev_reg & sda_sync_reg; // R3

   assign byte_in_done = (bit_cnt_reg == `BITS_PER_BYTE);

   // ack decision at the eighth falling edge
   always_comb
   begin
      unique case (byte_cnt_reg)
         `BYTE_IDX_ADDR:
            accept_byte = (shift_reg[7:1] == own_addr); // R9 R16
         `BYTE_IDX_POINTER:
            accept_byte = (shift_reg[0] | 1'b1); // R8
         default:
            // a full queue refuses the byte rather than lose it
            accept_byte = q_in_ready; // R8
      endcase
   end

   // data bytes land at the rise of the ack clock, never before
   assign commit_write = (state_reg == i2c_slave_pkg::ST_RX_ACK)
                         & scl_rise
                         & (byte_cnt_reg == `BYTE_IDX_DATA); // R12

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         busy_reg <= 1'b0;
      end
      else if (start_det)
      begin
         busy_reg <= 1'b1; // R4
      end
      else if (stop_det)
      begin
         busy_reg <= 1'b0; // R4
      end
   end

   assign bus_busy = busy_reg;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= i2c_slave_pkg::ST_IDLE;
      end
      else if (start_det)
      begin
         state_reg <= i2c_slave_pkg::ST_RX; // R5
      end
      else if (stop_det)
      begin
         // partial byte is dropped; nothing was queued for it
         state_reg <= i2c_slave_pkg::ST_IDLE; // R2
      end
      else if (scl_fall)
      begin
         unique case (state_reg)
            i2c_slave_pkg::ST_IDLE:
               state_reg <= i2c_slave_pkg::ST_IDLE;
            i2c_slave_pkg::ST_RX:
               if (byte_in_done)
               begin
                  state_reg <= accept_byte ? i2c_slave_pkg::ST_RX_ACK
                                           : i2c_slave_pkg::ST_IDLE; // R16
               end
            i2c_slave_pkg::ST_RX_ACK:
               if (byte_cnt_reg == `BYTE_IDX_ADDR
                   && dir_reg == `DIR_READ)
               begin
                  state_reg <= i2c_slave_pkg::ST_TX; // R9
               end
               else
               begin
                  state_reg <= i2c_slave_pkg::ST_RX;
               end
            i2c_slave_pkg::ST_TX:
               if (byte_in_done)
               begin
                  state_reg <= i2c_slave_pkg::ST_TX_ACK; // R7
               end
            i2c_slave_pkg::ST_TX_ACK:
               state_reg <= master_ack_reg ? i2c_slave_pkg::ST_TX
                                           : i2c_slave_pkg::ST_IDLE; // R17
         endcase
      end
   end

   // bit counter: eight data clocks then the ninth is the ack
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         bit_cnt_reg <= 4'h0;
      end
      else if (start_det)
      begin
         bit_cnt_reg <= 4'h0; // R5
      end
      else if (scl_rise
               && (state_reg == i2c_slave_pkg::ST_RX
                   || state_reg == i2c_slave_pkg::ST_TX))
      begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1; // R6
      end
      else if (scl_fall
               && (state_reg == i2c_slave_pkg::ST_RX_ACK
                   || state_reg == i2c_slave_pkg::ST_TX_ACK))
      begin
         bit_cnt_reg <= 4'h0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         byte_cnt_reg <= `BYTE_IDX_ADDR;
      end
      else if (start_det)
      begin
         byte_cnt_reg <= `BYTE_IDX_ADDR; // R5
      end
      else if (scl_fall && state_reg == i2c_slave_pkg::ST_RX_ACK
               && byte_cnt_reg != `BYTE_IDX_DATA)
      begin
         byte_cnt_reg <= byte_cnt_reg + 2'h1; // R11
      end
   end

   // shifter: in at scl rise, out at scl fall, msb first
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         shift_reg <= 8'h00;
      end
      else if (scl_rise && state_reg == i2c_slave_pkg::ST_RX)
      begin
         shift_reg <= {shift_reg[6:0], sda_sync_reg}; // R1 R6
      end
      else if (scl_fall && state_reg == i2c_slave_pkg::ST_RX_ACK
               && byte_cnt_reg == `BYTE_IDX_ADDR
               && dir_reg == `DIR_READ)
      begin
         shift_reg <= rd_data; // R17
      end
      else if (scl_fall && state_reg == i2c_slave_pkg::ST_TX_ACK
               && master_ack_reg)
      begin
         shift_reg <= rd_data; // R17
      end
      else if (scl_fall && state_reg == i2c_slave_pkg::ST_TX
               && !byte_in_done)
      begin
         shift_reg <= {shift_reg[6:0], 1'b0}; // R6
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dir_reg <= `DIR_WRITE;
      end
      else if (scl_rise && state_reg == i2c_slave_pkg::ST_RX_ACK
               && byte_cnt_reg == `BYTE_IDX_ADDR)
      begin
         dir_reg <= shift_reg[0]; // R9
      end
   end

   // pointer survives a repeated start so a read follows a pointer write
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         pointer_reg <= 8'h00;
      end
      else if (scl_rise && state_reg == i2c_slave_pkg::ST_RX_ACK
               && byte_cnt_reg == `BYTE_IDX_POINTER)
      begin
         pointer_reg <= shift_reg; // R11
      end
      else if (commit_write)
      begin
         pointer_reg <= next_ptr(pointer_reg); // R14
      end
      else if (scl_rise && state_reg == i2c_slave_pkg::ST_TX_ACK)
      begin
         pointer_reg <= next_ptr(pointer_reg); // R14
      end
   end

   assign rd_addr = pointer_reg;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         master_ack_reg <= 1'b0;
      end
      else if (scl_rise && state_reg == i2c_slave_pkg::ST_TX_ACK)
      begin
         master_ack_reg <= ~sda_sync_reg; // R17
      end
   end

   // sda is pulled only for our ack or a zero data bit; the last data bit
   // stands through its high phase, as an early release reads as a stop
   assign want_low = (state_reg == i2c_slave_pkg::ST_RX_ACK) // R8
                     | ((state_reg == i2c_slave_pkg::ST_TX)
                        & ~shift_reg[7]); // R1 R7 R17

   // the pin follows want_low only after the output hold time
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         hold_cnt_reg <= '0;
      end
      else if (scl_fall)
      begin
         hold_cnt_reg <= HW'(HOLD_CYC);
      end
      else if (hold_cnt_reg != '0)
      begin
         hold_cnt_reg <= hold_cnt_reg - HW'(1);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         sda_oe_n_reg <= 1'b1;
      end
      else if (hold_cnt_reg == '0 && !scl_fall)
      begin
         sda_oe_n_reg <= ~want_low; // R7
      end
   end

   assign sda_oe_n = sda_oe_n_reg;
   assign sda_o    = 1'b0;

   assign q_in_data.reg_addr = pointer_reg;
   assign q_in_data.reg_data = shift_reg;

   wr_cmd_fifo
   #(
      .WIDTH (16),
      .DEPTH (WR_DEPTH)
   )
   u_wr_fifo
   (
      .clk       (core_clk),
      .rst       (sys_rst),
      .in_valid  (commit_write),
      .in_ready  (q_in_ready),
      .in_data   (q_in_data),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_cmd)
   );

endmodule : i2c_register_access_slave
`default_nettype wire

// ==== test/i2c_slave_asserts.sv ====
// port checks for the two-wire register access slave
// assumes one core clock domain and a synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_asserts
#(
   parameter int HOLD_CYC = 30
)
(
   input wire logic                   core_clk,
   input wire logic                   sys_rst,
   input wire logic                   scl_i,
   input wire logic                   sda_i,
   input wire logic                   sda_o,
   input wire logic                   sda_oe_n,
   input wire logic                   addr_sel,
   input wire logic                   wr_valid,
   input wire logic                   wr_ready,
   input wire i2c_slave_pkg::wr_cmd_t wr_cmd,
   input wire logic [7:0]             rd_addr,
   input wire logic [7:0]             rd_data,
   input wire logic                   bus_busy
);
   logic [7:0] low_cnt_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // saturates so a long idle low never wraps back under the hold figure
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || scl_i)
         low_cnt_reg <= 8'h00;
      else if (low_cnt_reg != 8'hFF)
         low_cnt_reg <= low_cnt_reg + 8'h01;
   end

   a_oe_hold_time:
      assert property ($changed(sda_oe_n) |-> low_cnt_reg >= HOLD_CYC)
      else $error("sda enable moved too soon after scl fell");
   a_busy_on_start:
      assert property ($fell(sda_i) && scl_i && $past(scl_i)
                       |-> ##[1:8] bus_busy)
      else $error("start not seen as busy");
   a_idle_on_stop:
      assert property ($rose(sda_i) && scl_i && $past(scl_i)
                       |-> ##[1:8] !bus_busy)
      else $error("stop not seen as idle");
   a_idle_released:
      assert property (!bus_busy |-> sda_oe_n)
      else $error("sda pulled while bus idle");
   a_push_on_rise:
      assert property ($rose(wr_valid) |-> scl_i && $past(scl_i, 3))
      else $error("write issued away from an scl high phase");
   a_head_stands:
      assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_cmd))
      else $error("stalled write changed or vanished");
   a_ptr_on_high:
      assert property ($changed(rd_addr) |-> scl_i)
      else $error("pointer moved while scl low");
   a_drive_low:
      assert property (!sda_oe_n |-> !sda_o)
      else $error("sda driven high");

   cover property (wr_valid && wr_ready);
   cover property (wr_valid && !wr_ready);
   cover property ($fell(bus_busy));
endmodule : i2c_slave_asserts

bind i2c_register_access_slave i2c_slave_asserts
   #(.HOLD_CYC (HOLD_CYC)) u_chk
   (.core_clk (core_clk), .sys_rst (sys_rst), .scl_i (scl_i),
    .sda_i (sda_i), .sda_o (sda_o), .sda_oe_n (sda_oe_n),
    .addr_sel (addr_sel), .wr_valid (wr_valid), .wr_ready (wr_ready),
    .wr_cmd (wr_cmd), .rd_addr (rd_addr), .rd_data (rd_data),
    .bus_busy (bus_busy));
`default_nettype wire

// ==== test/i2c_master_model.sv ====
// two-wire bus master driving scl and an open-drain sda
// assumes the bench forms sda_line as the pulled-up and of all drivers
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model
(
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   // 65 ns low and 60 ns high; scl rests high between frames
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic start_cond();
      #20 sda_drv = 1'b1;
      #45 scl = 1'b1;
      #60 sda_drv = 1'b0;
      #60 scl = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      #20 sda_drv = 1'b0;
      #45 scl = 1'b1;
      #60 sda_drv = 1'b1;
      #150;
   endtask : stop_cond

   // sampled at the end of the high phase, past the slave's hold time
   task automatic bit_cycle(input logic b, output logic seen);
      #20 sda_drv = b;
      #45 scl = 1'b1;
      #60 seen = sda_line;
      scl = 1'b0;
   endtask : bit_cycle

   // send 8'hFF to receive; ack_lvl 1 releases sda for the slave
   task automatic xfer_byte(input logic [7:0] tx, input logic ack_lvl,
                            output logic [7:0] rx, output logic ack_seen);
      for (int i = 7; i >= 0; i--)
         bit_cycle(tx[i], rx[i]);
      bit_cycle(ack_lvl, ack_seen);
   endtask : xfer_byte
endmodule : i2c_master_model
`default_nettype wire

// ==== test/i2c_register_access_slave_tb_top.sv ====
// self-checking bench for the two-wire register access slave
// assumes the master model; the bench itself plays the register map
`timescale 1ns/100ps
`default_nettype none
module i2c_register_access_slave_tb_top;
   logic                   core_clk;
   logic                   sys_rst;
   logic                   addr_sel;
   logic                   wr_ready;
   logic [7:0]             rd_data;
   logic                   sda_o;
   logic                   sda_oe_n;
   logic                   wr_valid;
   logic [7:0]             rd_addr;
   logic                   bus_busy;
   logic                   scl;
   logic                   mst_sda;
   wire logic              sda_line;
   i2c_slave_pkg::wr_cmd_t wr_cmd;
   i2c_slave_pkg::wr_cmd_t wr_q[$];
   logic [7:0]             regs[256];
   int                     fails;
   int                     checks;

   assign sda_line = mst_sda & (sda_oe_n | sda_o);

   i2c_register_access_slave #(.WR_DEPTH (16), .HOLD_CYC (1)) uut
   (.core_clk (core_clk), .sys_rst (sys_rst), .scl_i (scl),
    .sda_i (sda_line), .sda_o (sda_o), .sda_oe_n (sda_oe_n),
    .addr_sel (addr_sel), .wr_valid (wr_valid), .wr_ready (wr_ready),
    .wr_cmd (wr_cmd), .rd_addr (rd_addr), .rd_data (rd_data),
    .bus_busy (bus_busy));

   i2c_master_model mst (.sda_line (sda_line), .scl (scl), .sda_drv (mst_sda));

   // register map: takes queued writes, answers the pointer next edge
   always @(posedge core_clk)
   begin
      rd_data <= regs[rd_addr];
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
      begin
         regs[wr_cmd.reg_addr] <= wr_cmd.reg_data;
         wr_q.push_back(wr_cmd);
      end
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   task automatic send(input logic [7:0] b, input logic lvl);
      logic [7:0] rx;
      logic       ack;
      mst.xfer_byte(b, 1'b1, rx, ack);
      check("ack", ack, lvl);
   endtask : send

   task automatic t_reset();
      check("oe_n", sda_oe_n, 1'b1);
      check("busy", bus_busy, 1'b0);
      check("valid", wr_valid, 1'b0);
   endtask : t_reset

   task automatic t_write();
      mst.start_cond();
      send(8'hA8, 1'b0);
      send(8'h10, 1'b0);
      check("busy", bus_busy, 1'b1);
      send(8'hA5, 1'b0);
      send(8'h3C, 1'b0);
      mst.stop_cond();
      check("busy", bus_busy, 1'b0);
      check("wr0", wr_q.pop_front(), 16'h10A5);
      check("wr1", wr_q.pop_front(), 16'h113C);
   endtask : t_write

   // both strap levels against both addresses; a miss is ignored
   task automatic t_strap();
      for (int s = 0; s < 2; s++)
      begin
         @(posedge core_clk);
         addr_sel <= 1'(s);
         repeat (4) @(posedge core_clk);
         for (int a = 0; a < 2; a++)
         begin
            mst.start_cond();
            send({7'h54 + 7'(a), 1'b0}, a != s);
            send(8'h00, a != s);
            mst.stop_cond();
         end
      end
      @(posedge core_clk);
      addr_sel <= 1'b0;
      check("nwr", 16'(wr_q.size()), 16'h0000);
   endtask : t_strap

   task automatic t_read();
      logic [7:0] rx;
      logic       ack;
      mst.start_cond();
      send(8'hA8, 1'b0);
      send(8'h20, 1'b0);
      mst.start_cond();
      send(8'hA9, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         mst.xfer_byte(8'hFF, i == 2, rx, ack);
         check("rd", rx, 8'h20 + 8'(i) ^ 8'h5A);
      end
      mst.stop_cond();
      check("ptr", rd_addr, 8'h23);
   endtask : t_read

   // stop mid-byte discards; a repeated start mid-byte restarts cleanly
   task automatic t_abort();
      logic b;
      mst.start_cond();
      send(8'hA8, 1'b0);
      send(8'h30, 1'b0);
      for (int i = 0; i < 4; i++)
         mst.bit_cycle(1'b1, b);
      mst.stop_cond();
      check("busy", bus_busy, 1'b0);
      mst.start_cond();
      send(8'hA8, 1'b0);
      send(8'h40, 1'b0);
      for (int i = 0; i < 3; i++)
         mst.bit_cycle(1'b0, b);
      mst.start_cond();
      send(8'hA8, 1'b0);
      send(8'h41, 1'b0);
      send(8'h77, 1'b0);
      mst.stop_cond();
      check("nwr", 16'(wr_q.size()), 16'h0001);
      check("wr", wr_q.pop_front(), 16'h4177);
   endtask : t_abort

   // 16 queued plus the head word fill up; the next byte is refused
   task automatic t_fifo();
      @(posedge core_clk);
      wr_ready <= 1'b0;
      mst.start_cond();
      send(8'hA8, 1'b0);
      send(8'h60, 1'b0);
      for (int i = 0; i < 17; i++)
         send(8'h80 + 8'(i), 1'b0);
      send(8'hEE, 1'b1);
      mst.stop_cond();
      check("head", wr_cmd, 16'h6080);
      @(posedge core_clk);
      wr_ready <= 1'b1;
      for (int n = 0; n < 200 && wr_q.size() < 17; n++)
         @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      check("valid", wr_valid, 1'b0);
      check("nwr", 16'(wr_q.size()), 16'h0011);
      for (int i = 0; i < 17; i++)
         check("wr", wr_q.pop_front(), {8'h60 + 8'(i), 8'h80 + 8'(i)});
   endtask : t_fifo

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // the tests need about 57 us; three and a half times that means a hang
   initial
   begin
      #200000;
      fails++;
      tally_and_finish();
   end

   initial
   begin
      fails = 0;
      checks = 0;
      sys_rst = 1'b1;
      addr_sel = 1'b0;
      wr_ready = 1'b1;
      for (int i = 0; i < 256; i++)
         regs[i] = 8'(i) ^ 8'h5A;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge core_clk);
      t_reset();
      t_write();
      t_strap();
      t_read();
      t_abort();
      t_fifo();
      tally_and_finish();
   end
endmodule : i2c_register_access_slave_tb_top
`default_nettype wire
